/* rtl/itcc_defines.vh */
`ifndef ITCC_DEFINES_VH
`define ITCC_DEFINES_VH
`define ITCC_SET_BASE      12'h200
`define ITCC_CLR_BASE      12'h204
`define ITCC_CTX_STRIDE    12'h010
`define ITCC_IRQ_STAT_OFF  12'h300
`define ITCC_IRQ_CLR_OFF   12'h304
`define ITCC_IRQ_EN_OFF    12'h308
`define ITCC_BIT_ARM       31
`define ITCC_TGT_HI        30
`define ITCC_TGT_LO        16
`define ITCC_BIT_RUN       15
`define ITCC_BIT_WAKE      12
`define ITCC_BIT_DEAD      11
`define ITCC_BIT_ACTIVE    10
`define ITCC_SPD_HI        7
`define ITCC_SPD_LO        5
`define ITCC_EVT_HI        4
`define ITCC_EVT_LO        0
`define ITCC_SET_MASK      32'hffff9000
`define ITCC_CLR_MASK      32'hffff8000
`define ITCC_RESET_VALUE   32'h00000000
`define ITCC_EVT_COMPLETE  5'h11
`define ITCC_EVT_DESC_RD   5'h05
`define ITCC_EVT_DATA_RD   5'h07
`define ITCC_EVT_UNKNOWN   5'h0e
`endif

/* rtl/itcc_ctx.v */
`timescale 1ns/10ps
`include "itcc_defines.vh"
module itcc_ctx
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        soft_reset,
  input  wire        wr_set,
  input  wire        wr_clr,
  input  wire [31:0] wdata,
  input  wire [14:0] timer_now,
  input  wire        fetch,
  input  wire        busy,
  input  wire        fatal,
  input  wire        done,
  input  wire [4:0]  done_code,
  output wire [31:0] ctrl,
  output wire        tx_permit,
  output wire        ev_done,
  output wire        ev_dead
);
  reg        arm_q;
  reg [14:0] tgt_q;
  reg        run_q;
  reg        wake_q;
  reg        dead_q;
  reg        active_q;
  reg [4:0]  evt_q;
  reg        permit_q;
  wire match = arm_q && (timer_now == tgt_q);
  assign tx_permit = run_q && !dead_q && (!arm_q || permit_q || match);
  assign ev_done   = done && run_q;
  assign ev_dead   = fatal && run_q && !dead_q;
  assign ctrl = {arm_q, tgt_q, run_q, 2'b00, wake_q, dead_q, active_q, 2'b00, 3'b000, evt_q};
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arm_q    <= 1'b0;
      tgt_q    <= 15'h0000;
      run_q    <= 1'b0;
      wake_q   <= 1'b0;
      dead_q   <= 1'b0;
      active_q <= 1'b0;
      evt_q    <= 5'h00;
      permit_q <= 1'b0;
    end
    else if (soft_reset)
    begin
      run_q    <= 1'b0;
      dead_q   <= 1'b0;
      active_q <= 1'b0;
      wake_q   <= 1'b0;
      permit_q <= 1'b0;
    end
    else
    begin
      if (wr_set)
      begin
        tgt_q <= tgt_q | wdata[`ITCC_TGT_HI:`ITCC_TGT_LO];
        if (wdata[`ITCC_BIT_RUN])
          run_q <= 1'b1;
      end
      if (wr_clr)
      begin
        tgt_q <= tgt_q & ~wdata[`ITCC_TGT_HI:`ITCC_TGT_LO];
        if (wdata[`ITCC_BIT_RUN])
          run_q <= 1'b0;
      end
      if (match)
        permit_q <= 1'b1;
      if (!run_q)
        permit_q <= 1'b0;
      if (active_q || (wr_clr && wdata[`ITCC_BIT_ARM]))
        arm_q <= 1'b0;
      else if (wr_set && wdata[`ITCC_BIT_ARM])
        arm_q <= 1'b1;
      if (wr_set && wdata[`ITCC_BIT_WAKE])
        wake_q <= 1'b1;
      else if (fetch)
        wake_q <= 1'b0;
      if (fatal && run_q)
        dead_q <= 1'b1;
      else if (wr_clr && wdata[`ITCC_BIT_RUN])
        dead_q <= 1'b0;
      active_q <= busy && run_q && !dead_q;
      if (done)
        evt_q <= done_code;
    end
  end
endmodule // itcc_ctx

/* rtl/itcc_top.v */
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`include "itcc_defines.vh"
module itcc_top
#(
  parameter NCTX = 8
)
(
  input  wire            pclk,
  input  wire            presetn,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [11:0]     paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output wire            pready,
  output wire            pslverr,
  input  wire            soft_reset,
  input  wire [6:0]      timer_seconds,
  input  wire [12:0]     timer_cycle_count,
  input  wire [NCTX-1:0] desc_fetch,
  input  wire [NCTX-1:0] ctx_busy,
  input  wire [NCTX-1:0] ctx_fatal,
  input  wire [NCTX-1:0] out_last_done,
  input  wire [4:0]      out_last_code,
  output wire [NCTX-1:0] ctx_tx_permit,
  output wire [NCTX-1:0] ctx_run,
  output wire [NCTX-1:0] ctx_wake,
  output wire            irq
);
  wire        acc = psel && penable;
  wire [31:0] ctrl_all [0:NCTX-1];
  wire [NCTX-1:0] ev_done;
  wire [NCTX-1:0] ev_dead;
  wire [14:0] timer_now = {timer_seconds[1:0], timer_cycle_count};
  reg  [15:0] istat_q;
  reg  [15:0] ien_q;
  reg         hit;
  integer     k;
  function is_ctx;
    input [11:0] a;
    input [11:0] base;
    input integer n;
    begin
      is_ctx = (a == (base + `ITCC_CTX_STRIDE * n[7:0]));
    end
  endfunction
  genvar g;
  generate
    for (g = 0; g < NCTX; g = g + 1)
    begin : ctx
      itcc_ctx u_ctx
      (
        .pclk       (pclk),
        .presetn    (presetn),
        .soft_reset (soft_reset),
        .wr_set     (acc && pwrite && is_ctx(paddr, `ITCC_SET_BASE, g)),
        .wr_clr     (acc && pwrite && is_ctx(paddr, `ITCC_CLR_BASE, g)),
        .wdata      (pwdata),
        .timer_now  (timer_now),
        .fetch      (desc_fetch[g]),
        .busy       (ctx_busy[g]),
        .fatal      (ctx_fatal[g]),
        .done       (out_last_done[g]),
        .done_code  (out_last_code),
        .ctrl       (ctrl_all[g]),
        .tx_permit  (ctx_tx_permit[g]),
        .ev_done    (ev_done[g]),
        .ev_dead    (ev_dead[g])
      );
      assign ctx_run[g]  = ctrl_all[g][`ITCC_BIT_RUN];
      assign ctx_wake[g] = ctrl_all[g][`ITCC_BIT_WAKE];
    end
  endgenerate
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  always @*
  begin
    prdata = 32'h00000000;
    hit    = 1'b0;
    for (k = 0; k < NCTX; k = k + 1)
    begin
      if (is_ctx(paddr, `ITCC_SET_BASE, k) || is_ctx(paddr, `ITCC_CLR_BASE, k))
      begin
        prdata = ctrl_all[k];
        hit    = 1'b1;
      end
    end
    if (!hit)
    begin
      if (paddr == `ITCC_IRQ_STAT_OFF)
        prdata = {16'h0000, istat_q};
      else if (paddr == `ITCC_IRQ_EN_OFF)
        prdata = {16'h0000, ien_q};
    end
  end
  wire [15:0] ev_all = {ev_dead, ev_done};
  wire        wr_iclr = acc && pwrite && (paddr == `ITCC_IRQ_CLR_OFF);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      istat_q <= 16'h0000;
      ien_q   <= 16'h0000;
    end
    else
    begin
      istat_q <= (istat_q & ~(wr_iclr ? pwdata[15:0] : 16'h0000)) | ev_all;
      if (acc && pwrite && (paddr == `ITCC_IRQ_EN_OFF))
        ien_q <= pwdata[15:0];
    end
  end
  assign irq = |(istat_q & ien_q);
endmodule // itcc_top

/* dv/itcc_sva.sv */
`timescale 1ns/10ps
module itcc_sva #(parameter NCTX = 8) (
  input wire            pclk,
  input wire            presetn,
  input wire            psel,
  input wire            penable,
  input wire            pwrite,
  input wire [11:0]     paddr,
  input wire [31:0]     pwdata,
  input wire [31:0]     prdata,
  input wire            soft_reset,
  input wire [NCTX-1:0] desc_fetch,
  input wire [NCTX-1:0] ctx_tx_permit,
  input wire [NCTX-1:0] ctx_run,
  input wire [NCTX-1:0] ctx_wake
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ws = psel & penable & pwrite & (paddr == 12'h200);
  wire wc = psel & penable & pwrite & (paddr == 12'h204);
  wire rc = psel & penable & !pwrite & (paddr == 12'h200 || paddr == 12'h204);
  chk_run_cause: assert property (!$stable(ctx_run[0]) |-> $past(ws | wc | soft_reset))
    else $error("run moved by itself");
  chk_wake_fetch: assert property (desc_fetch[0] && !ws |=> !ctx_wake[0])
    else $error("wake kept after fetch");
  chk_permit_run: assert property (ctx_tx_permit[0] |-> ctx_run[0])
    else $error("permit without run");
  chk_resvd_zero: assert property (rc |-> prdata[14:13] == 2'h0 && prdata[9:5] == 5'h0)
    else $error("reserved bits set");
  chk_read_value: assert property (rc |-> prdata[15] == ctx_run[0] && prdata[12] == ctx_wake[0])
    else $error("read differs");
  chk_soft_clear: assert property (soft_reset |=> ctx_run == 0 && ctx_wake == 0)
    else $error("soft reset kept bits");
  chk_run_set: assert property (ws && pwdata[15] && !soft_reset |=> ctx_run[0])
    else $error("run not set");
  chk_run_clear: assert property (wc && pwdata[15] |=> !ctx_run[0])
    else $error("run not cleared");
endmodule // itcc_sva
bind itcc_top itcc_sva #(.NCTX(NCTX)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .soft_reset(soft_reset),
  .desc_fetch(desc_fetch), .ctx_tx_permit(ctx_tx_permit), .ctx_run(ctx_run), .ctx_wake(ctx_wake));

/* dv/iso_tx_context_control_bench.sv */
`timescale 1ns/10ps
`include "itcc_defines.vh"
module iso_tx_context_control_bench;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, soft_reset = 0;
  reg  [11:0] paddr = 0, b;
  reg  [31:0] pwdata = 0, rd, lf = 32'hd3fccdf0;
  reg  [6:0]  sec = 0;
  reg  [12:0] cyc = 0;
  reg  [7:0]  fet = 0, bsy = 0, fat = 0, dn = 0;
  reg  [4:0]  code = 0;
  reg  [19:0] codes = {`ITCC_EVT_COMPLETE, `ITCC_EVT_DESC_RD, `ITCC_EVT_DATA_RD, `ITCC_EVT_UNKNOWN};
  wire [31:0] prdata;
  wire [7:0]  permit, run, wake;
  wire        pready, pslverr, irq;
  integer     fails = 0, n_checks = 0, i;
  always #5 pclk = ~pclk;
  itcc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .soft_reset(soft_reset), .timer_seconds(sec), .timer_cycle_count(cyc), .desc_fetch(fet),
    .ctx_busy(bsy), .ctx_fatal(fat), .out_last_done(dn), .out_last_code(code),
    .ctx_tx_permit(permit), .ctx_run(run), .ctx_wake(wake), .irq(irq));
  function [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rdchk(input [11:0] a, input [31:0] m, input [31:0] e);
    apb(0, a, 0);
    chk(rd & m, e);
    chk(pslverr, 0);
  endtask
  task strobe(input [23:0] v);
    {dn, fat, fet} <= v;
    @(posedge pclk);
    {dn, fat, fet} <= 0;
  endtask
  task complete_run;
    if (fails == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #300000;
    fails = fails + 1;
    complete_run;
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (i = 0; i < 8; i = i + 1)
    begin
      b = {4'h2, i[3:0], 4'h0};
      lf = nxt(lf);
      rdchk(b, 32'h0000ef00, 0);
      apb(1, b, {lf[31:16], 16'h9000});
      rdchk(b | 12'h4, 32'hffffffe0, {lf[31:16], 16'h9000});
      chk(permit[i], !lf[31] || lf[30:16] == 0);
      apb(1, b | 12'h4, 32'hffff9000);
      rdchk(b, 32'hffff9000, 32'h1000);
      strobe(24'h1 << i);
      rdchk(b, 32'h1000, 0);
    end
    apb(1, 12'h200, 32'h8000);
    strobe(24'h100);
    rdchk(12'h200, 32'h8800, 32'h8800);
    apb(1, 12'h204, 32'h8000);
    rdchk(12'h200, 32'h8800, 0);
    sec <= {lf[6:2], ~lf[14:13]};
    cyc <= lf[12:0];
    apb(1, 12'h200, {1'b1, lf[14:0], 16'h8000});
    chk(permit[0], 0);
    sec <= {lf[6:2], lf[14:13]};
    @(posedge pclk);
    chk(permit[0], 1);
    bsy <= 1;
    repeat (3) @(posedge pclk);
    rdchk(12'h200, 32'h80000400, 32'h400);
    bsy <= 0;
    repeat (3) @(posedge pclk);
    rdchk(12'h200, 32'h400, 0);
    apb(1, 12'h308, 1);
    for (i = 0; i < 4; i = i + 1)
    begin
      code <= codes[5 * i +: 5];
      strobe(24'h10000);
      rdchk(12'h200, 32'h1f, codes[5 * i +: 5]);
    end
    chk(irq, 1);
    apb(1, 12'h304, 1);
    chk(irq, 0);
    rdchk(12'h3fc, 32'hffffffff, 0);
    soft_reset <= 1;
    @(posedge pclk);
    soft_reset <= 0;
    rdchk(12'h200, 32'h9000, 0);
    complete_run;
  end
endmodule // iso_tx_context_control_bench
